// File: fca_pkg.sv
package fca_pkg;

  // Register offsets
  localparam logic [7:0] OFS_AMB_COEF = 8'h0C;
  localparam logic [7:0] OFS_AMB_OVL  = 8'h0D;
  localparam logic [7:0] OFS_FCAL_CTL = 8'h0F;
  localparam logic [7:0] OFS_AMP_FCNT = 8'h10;

  // Reset values
  localparam logic [23:0] RST_AMB_COEF = 24'h000000;
  localparam logic [23:0] RST_AMB_OVL  = 24'h006000;
  localparam logic [23:0] RST_FCAL_CTL = 24'h144C4B;
  localparam logic [14:0] RST_MEAS     = 15'h4000;

  // Field positions in register 0Ch
  localparam int PWL0_LSB = 16;
  localparam int XQ_LSB   = 8;
  localparam int XI_LSB   = 0;

  // Field positions in register 0Dh
  localparam int TEMPW_BIT = 23;
  localparam int THR_LSB   = 7;
  localparam int THR_MSB   = 16;

  // Field positions in register 0Fh
  localparam int CORR_EN_BIT  = 23;
  localparam int BLK_EN_BIT   = 22;
  localparam int SRC_SEL_BIT  = 21;
  localparam int DIV_LSB      = 17;
  localparam int DIV_MSB      = 20;
  localparam int START_BIT    = 16;
  localparam int LIMIT_MSB    = 14;

  // Field positions in amplitude_threshold_high_and_freq_count
  localparam int AMPH_LSB = 16;
  localparam int CONT_BIT = 15;

  // Writable masks; reserved bits stay zero
  localparam logic [23:0] MASK_AMB_OVL  = 24'h81FF80;
  localparam logic [23:0] MASK_FCAL_CTL = 24'hFF7FFF;
  localparam logic [23:0] MASK_AMP_FCNT = 24'hFF8000;

  // Unity correction factor and its fraction width
  localparam logic [14:0] UNITY     = 15'h4000;
  localparam int          FRAC_BITS = 14;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_COUNT} fca_state_t;

endpackage : fca_pkg

// File: fca_regs.sv
`timescale 1ns/1ps
// Function
// - Correct phase only while correction enable set
// - Calibration block runs only while enabled
// - Source select picks trimmed or measured value
// - Divider field sets power-of-two clock division
// - Writing start bit begins a measurement
// - Count limit field sets nominal reference count
// - Ten-bit ambient overload threshold, reset C0h
// - Width bit selects 8 or 12-bit temperature
// - Register 0Ch high byte: PWL coefficient zero
// - Middle byte: quadrature crosstalk coefficient
// - Low byte: in-phase crosstalk coefficient
// - Amplitude_threshold_high_and_freq_count resets to 4000h
// - Continuous bit repeats measurements without start
// - Measured value readable at 10h bits 14:0
// - Trimmed value used when source select clear
// - Overload compares against calibrated ambient value
module fca_regs (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [23:0] reg_wdata_in,
  output logic      [23:0] reg_rdata_out,
  input  wire logic        general_purpose_pin_two_in,
  input  wire logic [15:0] phase_in,
  input  wire logic [9:0]  ambient_measurement_in,
  input  wire logic [9:0]  calibrated_ambient_value_in,
  input  wire logic [14:0] trimmed_frequency_count_in,
  output logic      [15:0] phase_out,
  output logic             ambient_overload_flag_out,
  output logic             calibration_block_enable_out,
  output logic             calibration_busy_out,
  output logic             temperature_width_select_out,
  output logic      [7:0]  ambient_pwl_coefficient_zero_out,
  output logic      [7:0]  ambient_quadrature_crosstalk_coeff_out,
  output logic      [7:0]  ambient_inphase_crosstalk_coeff_out,
  output logic      [7:0]  minimum_amplitude_threshold_high_out
);

  typedef struct packed {
    logic [23:0]         r0c;
    logic [23:0]         r0d;
    logic [23:0]         r0f;
    logic [8:0]          r10;       // Threshold high byte and continuous bit
    logic [14:0]         meas;
    logic [2:0]          sync;
    logic                ref_lvl;
    logic [15:0]         pre;
    logic [14:0]         ticks;
    fca_pkg::fca_state_t st;
    logic [23:0]         rdata;
    logic [15:0]         phase;
    logic                ovl;
    logic                busy;      // Measurement armed or counting
  } fca_state_s_t;

  fca_state_s_t q, d;

  // Tick mask for a divide by two to the power div
  function automatic logic [15:0] div_mask(input logic [3:0] div);
    div_mask = (16'h0001 << div) - 16'h0001;
  endfunction : div_mask

  // Correction factor from ticks, unity when ticks equal limit; saturates
  function automatic logic [14:0] meas_val(input logic [14:0] ticks, input logic [14:0] lim);
    logic [16:0] v;
    v = {2'b00, fca_pkg::UNITY} + {2'b00, lim} - {2'b00, ticks};
    if (v[16])
      meas_val = 15'h0000;
    else if (v[15])
      meas_val = 15'h7FFF;
    else
      meas_val = v[14:0];
  endfunction : meas_val

  logic        corr_en, blk_en, src_sel, start_wr, cont, ref_rise, tick;
  logic [3:0]  divider;
  logic [14:0] limit, corr;
  logic [30:0] prod;
  logic [10:0] amb_diff;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  always_comb
  begin
    corr_en  = q.r0f[fca_pkg::CORR_EN_BIT];
    blk_en   = q.r0f[fca_pkg::BLK_EN_BIT];
    src_sel  = q.r0f[fca_pkg::SRC_SEL_BIT];
    divider  = q.r0f[fca_pkg::DIV_MSB:fca_pkg::DIV_LSB];
    limit    = q.r0f[fca_pkg::LIMIT_MSB:0];
    cont     = q.r10[0];
    start_wr = reg_wr_in && reg_addr_in == fca_pkg::OFS_FCAL_CTL
               && reg_wdata_in[fca_pkg::START_BIT];
    ref_rise = q.sync[2] == q.sync[1] && q.sync[2] && !q.ref_lvl;
    tick     = (q.pre & div_mask(divider)) == div_mask(divider);
    corr     = src_sel ? q.meas : trimmed_frequency_count_in;
    prod     = phase_in * corr;
    amb_diff = {1'b0, ambient_measurement_in} - {1'b0, calibrated_ambient_value_in};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    // Register writes; reserved bits masked so they read back zero
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        fca_pkg::OFS_AMB_COEF: d.r0c = reg_wdata_in;
        fca_pkg::OFS_AMB_OVL:  d.r0d = reg_wdata_in & fca_pkg::MASK_AMB_OVL;
        fca_pkg::OFS_FCAL_CTL: d.r0f = reg_wdata_in & fca_pkg::MASK_FCAL_CTL;
        fca_pkg::OFS_AMP_FCNT: d.r10 = reg_wdata_in[23:15];
        default: ;
      endcase
    end
    // Three-stage reference synchroniser; level moves once stages two and three agree
    d.sync = {q.sync[1:0], general_purpose_pin_two_in};
    if (q.sync[2] == q.sync[1])
      d.ref_lvl = q.sync[2];
    // Measurement: count divided clock ticks over one reference period
    d.pre = q.pre + 16'h0001;
    unique case (q.st)
      fca_pkg::ST_IDLE:
        if (blk_en && (start_wr || cont))
          d.st = fca_pkg::ST_WAIT;
      fca_pkg::ST_WAIT:
        if (ref_rise)
        begin
          d.st    = fca_pkg::ST_COUNT;
          d.pre   = 16'h0000;
          d.ticks = 15'h0000;
        end
      fca_pkg::ST_COUNT:
      begin
        if (tick && q.ticks != 15'h7FFF)
          d.ticks = q.ticks + 15'h0001;
        if (ref_rise)
        begin
          d.meas = meas_val(q.ticks, limit);
          d.st   = cont ? fca_pkg::ST_WAIT : fca_pkg::ST_IDLE;
        end
      end
      default: d.st = fca_pkg::ST_IDLE;
    endcase
    // Block disabled: measurement abandoned, last result kept
    if (!blk_en)
      d.st = fca_pkg::ST_IDLE;
    // Busy kept in its own flop so the output needs no decode after the register
    d.busy = d.st != fca_pkg::ST_IDLE;
    // Phase path
    d.phase = corr_en ? prod[fca_pkg::FRAC_BITS+15:fca_pkg::FRAC_BITS] : phase_in;
    // Ambient overload; negative difference never overloads
    d.ovl = !amb_diff[10] && amb_diff[9:0] > q.r0d[fca_pkg::THR_MSB:fca_pkg::THR_LSB];
    // Read data registered for the address presented this cycle
    unique case (reg_addr_in)
      fca_pkg::OFS_AMB_COEF: d.rdata = q.r0c;
      fca_pkg::OFS_AMB_OVL:  d.rdata = q.r0d;
      fca_pkg::OFS_FCAL_CTL: d.rdata = q.r0f;
      fca_pkg::OFS_AMP_FCNT: d.rdata = {q.r10, q.meas};
      default:               d.rdata = 24'h000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      q       <= '0;
      q.r0c   <= fca_pkg::RST_AMB_COEF;
      q.r0d   <= fca_pkg::RST_AMB_OVL;
      q.r0f   <= fca_pkg::RST_FCAL_CTL;
      q.meas  <= fca_pkg::RST_MEAS;
      q.st    <= fca_pkg::ST_IDLE;
    end
    else
      q <= d;
  end

  // Outputs straight from state flops
  assign reg_rdata_out                          = q.rdata;
  assign phase_out                              = q.phase;
  assign ambient_overload_flag_out              = q.ovl;
  assign calibration_block_enable_out           = blk_en;
  assign calibration_busy_out                   = q.busy;
  assign temperature_width_select_out           = q.r0d[fca_pkg::TEMPW_BIT];
  assign ambient_pwl_coefficient_zero_out       = q.r0c[fca_pkg::PWL0_LSB+7:fca_pkg::PWL0_LSB];
  assign ambient_quadrature_crosstalk_coeff_out = q.r0c[fca_pkg::XQ_LSB+7:fca_pkg::XQ_LSB];
  assign ambient_inphase_crosstalk_coeff_out    = q.r0c[fca_pkg::XI_LSB+7:fca_pkg::XI_LSB];
  assign minimum_amplitude_threshold_high_out   = q.r10[8:1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  freq_corr_off_a: assert property (!corr_en |=> phase_out == $past(phase_in))
    else $error("phase changed with correction off");
  trim_unity_a: assert property (corr_en && !src_sel && trimmed_frequency_count_in == fca_pkg::UNITY
                                 |=> phase_out == $past(phase_in))
    else $error("trimmed unity factor altered phase");
  block_off_a: assert property (!blk_en |=> !calibration_busy_out)
    else $error("measurement active with block disabled");
  start_begin_a: assert property (q.st == fca_pkg::ST_IDLE && blk_en && start_wr
                                  |=> q.st == fca_pkg::ST_WAIT)
    else $error("start write did not begin measurement");
  overload_set_a: assert property (!amb_diff[10] && amb_diff[9:0] > q.r0d[16:7]
                                   |=> ambient_overload_flag_out)
    else $error("overload flag not set");
  reserved_zero_a: assert property (reg_addr_in == fca_pkg::OFS_AMB_OVL
                                    |=> reg_rdata_out[22:17] == 6'h00 && reg_rdata_out[6:0] == 7'h00)
    else $error("reserved bits read nonzero");
  cont_repeat_a: assert property (q.st == fca_pkg::ST_COUNT && ref_rise && cont && blk_en
                                  |=> q.st == fca_pkg::ST_WAIT)
    else $error("continuous mode did not rearm");
  meas_store_a: assert property (q.st == fca_pkg::ST_COUNT && ref_rise && blk_en
                                 |=> q.meas == meas_val($past(q.ticks), $past(limit)))
    else $error("measured value not stored");
  ref_sync_a: assert property (general_purpose_pin_two_in [*5] |=> q.ref_lvl)
    else $error("reference level did not follow pin");

  meas_done_c: cover property (q.st == fca_pkg::ST_COUNT ##1 q.st == fca_pkg::ST_IDLE);
  overload_c:  cover property ($rose(ambient_overload_flag_out));
  cont_loop_c: cover property (cont && q.st == fca_pkg::ST_COUNT ##1 q.st == fca_pkg::ST_WAIT);

endmodule : fca_regs

// File: fca_ref_src.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Reference clock source on pin two; idles low while stopped
module fca_ref_src #(
  parameter real HALF_NS = 500.0
) (
  input  wire logic run_in,
  output logic      ref_out
);
  // Odd start offset keeps edges off the system clock grid
  initial
  begin
    ref_out = 1'b0;
    #3.0;
    forever #(HALF_NS) ref_out = run_in ? ~ref_out : 1'b0;
  end
endmodule : fca_ref_src

// File: fca_regs_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fca_regs_bench;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic [23:0] reg_wdata_in = 24'h000000;
  logic [23:0] reg_rdata_out;
  logic        ref_run = 1'b0;
  logic        ref_w;
  logic [15:0] phase_in = 16'h0000;
  logic [9:0]  amb = 10'h000;
  logic [9:0]  cal = 10'h000;
  logic [14:0] trim = 15'h0000;
  logic [15:0] phase_out;
  logic        ovl, blk_en, busy, tw;
  logic [7:0]  c0, cq, ci, amph;
  logic [23:0] v;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cycles = 0;
  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;
  fca_ref_src u_fca_ref_src (.run_in(ref_run), .ref_out(ref_w));
  fca_regs u_fca_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .general_purpose_pin_two_in(ref_w),
    .phase_in(phase_in), .ambient_measurement_in(amb), .calibrated_ambient_value_in(cal),
    .trimmed_frequency_count_in(trim), .phase_out(phase_out), .ambient_overload_flag_out(ovl),
    .calibration_block_enable_out(blk_en), .calibration_busy_out(busy), .temperature_width_select_out(tw),
    .ambient_pwl_coefficient_zero_out(c0), .ambient_quadrature_crosstalk_coeff_out(cq),
    .ambient_inphase_crosstalk_coeff_out(ci), .minimum_amplitude_threshold_high_out(amph));
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Range compare for measured values, which may differ by one tick
  task rng(input string name, input logic [23:0] s, input logic [23:0] lo, input logic [23:0] hi);
    check(name, {23'h0, (s >= lo && s <= hi)}, 24'h000001);
  endtask : rng
  // One-cycle write strobe, taken at the following edge
  task wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wr_in <= 1'b1;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    @(posedge clk_in);
    @(negedge clk_in);
    d = reg_rdata_out;
  endtask : rd
  task rdc(input logic [7:0] a, input logic [23:0] e);
    rd(a, v);
    check("rdata", v, e);
  endtask : rdc
  task settle;
    repeat (2) @(negedge clk_in);
  endtask : settle
  // Bounded wait for the busy flag to reach a level
  task wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 400)
    begin
      @(negedge clk_in);
      k++;
    end
    check("busy", {23'h0, busy}, {23'h0, lvl});
  endtask : wait_busy
  ////////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling against hangs
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdc(8'h0C, 24'h000000);
    rdc(8'h0D, 24'h006000);
    rdc(8'h0F, 24'h144C4B);
    rdc(8'h10, 24'h004000);
    rdc(8'h0E, 24'h000000);
    wr(8'h0C, 24'hA5C33C);
    rdc(8'h0C, 24'hA5C33C);
    check("coefs", {c0, cq, ci}, 24'hA5C33C);
    wr(8'h0D, 24'hFFFFFF);
    rdc(8'h0D, 24'h81FF80);
    wr(8'h10, 24'hFFFFFF);
    rdc(8'h10, 24'hFFC000);
    check("amp_high", {16'h0, amph}, 24'h0000FF);
    wr(8'h10, 24'h000000);
    // Threshold 5: differences 10, 5 and negative
    wr(8'h0D, 24'h800280);
    amb <= 10'h014;
    cal <= 10'h00A;
    settle();
    check("temp_width", {23'h0, tw}, 24'h000001);
    check("ovl", {23'h0, ovl}, 24'h000001);
    @(posedge clk_in);
    amb <= 10'h00F;
    settle();
    check("ovl", {23'h0, ovl}, 24'h000000);
    @(posedge clk_in);
    amb <= 10'h005;
    settle();
    check("ovl", {23'h0, ovl}, 24'h000000);
    // Trimmed factor one half
    @(posedge clk_in);
    trim <= 15'h2000;
    phase_in <= 16'h1234;
    settle();
    check("phase", {8'h0, phase_out}, 24'h001234);
    wr(8'h0F, 24'h800032);
    settle();
    check("phase", {8'h0, phase_out}, 24'h00091A);
    // Start ignored while block disabled
    ref_run <= 1'b1;
    wr(8'h0F, 24'h010032);
    settle();
    check("busy", {23'h0, busy}, 24'h000000);
    // Single measurement, divider 0: 40 ticks per period, limit 50
    // Start only counts once the block is already enabled
    wr(8'h0F, 24'h400032);
    wr(8'h0F, 24'h410032);
    wait_busy(1'b1);
    check("blk_en", {23'h0, blk_en}, 24'h000001);
    wait_busy(1'b0);
    rdc(8'h0F, 24'h410032);
    rd(8'h10, v);
    rng("meas", v, 24'h004009, 24'h00400B);
    // Continuous, divider 1, measured source: 20 ticks; arms without a start write
    wr(8'h0F, 24'hE20032);
    wr(8'h10, 24'h008000);
    wait_busy(1'b1);
    // Busy never drops in continuous mode, so wait out one full measurement
    repeat (120) @(negedge clk_in);
    check("busy", {23'h0, busy}, 24'h000001);
    rd(8'h10, v);
    rng("meas", v, 24'h00C01D, 24'h00C01F);
    @(posedge clk_in);
    phase_in <= 16'h4000;
    settle();
    rng("phase", {8'h0, phase_out}, 24'h00401D, 24'h00401F);
    wr(8'h0F, 24'h000032);
    settle();
    check("busy", {23'h0, busy}, 24'h000000);
    // Disabling keeps the last result
    rd(8'h10, v);
    rng("meas_kept", v, 24'h00C01D, 24'h00C01F);
    final_report();
  end
endmodule : fca_regs_bench
